/* File: shared/hxas_params.svh */
// Purpose: Constants for the halfword exchange add/subtract slice
// Assumes: 32-bit register file with sixteen registers
// Notes:   Field positions, special register indices and reset values
`ifndef HXAS_PARAMS_SVH
`define HXAS_PARAMS_SVH

`define HXAS_WORD_W        32
`define HXAS_HALF_W        16
`define HXAS_HI_MSB        31
`define HXAS_HI_LSB        16
`define HXAS_LO_MSB        15
`define HXAS_LO_LSB        0
`define HXAS_REG_IDX_W     4
`define HXAS_FLAG_W        4
`define HXAS_FLAG_N_POS    3
`define HXAS_FLAG_Z_POS    2
`define HXAS_FLAG_C_POS    1
`define HXAS_FLAG_V_POS    0
`define HXAS_SP_IDX        4'hD
`define HXAS_PC_IDX        4'hF
`define HXAS_RESULT_RST    32'h00000000
`define HXAS_REG_RST       4'h0
`define HXAS_FLAG_RST      4'h0
`define HXAS_LATENCY_CYC   1

`endif

/* File: shared/hxas_pkg.sv */
// Purpose: Types shared by the exchange slice modules
// Assumes: Nothing beyond the params header
// Notes:   One-hot state codes written out
`default_nettype none

package hxas_pkg;

	// Operation select coming from the decoder
	typedef enum logic
	{
		HXAS_ADD_SUB_EXCHANGE_OP = 1'b0,
		HXAS_SUB_ADD_EXCHANGE_OP = 1'b1
	} hxas_op_t;

	// Condition field encodings
	typedef enum logic [3:0]
	{
		HXAS_CC_EQ = 4'h0,
		HXAS_CC_NE = 4'h1,
		HXAS_CC_CS = 4'h2,
		HXAS_CC_CC = 4'h3,
		HXAS_CC_MI = 4'h4,
		HXAS_CC_PL = 4'h5,
		HXAS_CC_VS = 4'h6,
		HXAS_CC_VC = 4'h7,
		HXAS_CC_HI = 4'h8,
		HXAS_CC_LS = 4'h9,
		HXAS_CC_GE = 4'hA,
		HXAS_CC_LT = 4'hB,
		HXAS_CC_GT = 4'hC,
		HXAS_CC_LE = 4'hD,
		HXAS_CC_AL = 4'hE,
		HXAS_CC_NV = 4'hF
	} hxas_cond_t;

	// Writeback stage state
	typedef enum logic [2:0]
	{
		HXAS_ST_IDLE  = 3'b001,
		HXAS_ST_WRITE = 3'b010,
		HXAS_ST_SKIP  = 3'b100
	} hxas_state_t;

endpackage

`default_nettype wire

/* File: shared/hxas_lane_if.sv */
// Purpose: Carries halfword operands and results between core and lanes
// Assumes: Purely combinational lane unit
// Notes:   Core drives operands, lane unit drives results
`default_nettype none
`include "hxas_params.svh"

interface hxas_lane_if;
	logic [`HXAS_HALF_W-1:0] a_hi;
	logic [`HXAS_HALF_W-1:0] a_lo;
	logic [`HXAS_HALF_W-1:0] b_hi;
	logic [`HXAS_HALF_W-1:0] b_lo;
	hxas_pkg::hxas_op_t      op;
	logic [`HXAS_HALF_W-1:0] res_hi;
	logic [`HXAS_HALF_W-1:0] res_lo;

	modport core (output a_hi, output a_lo, output b_hi, output b_lo, output op,
		input res_hi, input res_lo);
	modport lane (input a_hi, input a_lo, input b_hi, input b_lo, input op,
		output res_hi, output res_lo);
endinterface

`default_nettype wire

/* File: rtl/hxas_lanes.sv */
// Purpose: Two independent sixteen-bit signed lanes of the exchange ops
// Assumes: Operands already split into halves by the core
// Notes:   Combinational; the core registers the results
`default_nettype none
`include "hxas_params.svh"

module hxas_lanes
(
	hxas_lane_if.lane lanes
);

	// Wrapping sum or difference, only the low sixteen bits survive
	function automatic logic [`HXAS_HALF_W-1:0] hxas_wrap
	(
		input logic [`HXAS_HALF_W-1:0] x,
		input logic [`HXAS_HALF_W-1:0] y,
		input logic                    sub
	);
		logic [`HXAS_HALF_W-1:0] r;
		r = sub ? (x - y) : (x + y);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// One lane per halfword; no carry path joins them
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_lane
			if (g == 1)
			begin : gen_top
				// Both ops add first.hi and second.lo into the top
				assign lanes.res_hi = hxas_wrap(lanes.a_hi, lanes.b_lo, 1'b0);
			end
			else
			begin : gen_bot
				logic sa;
				assign sa = (lanes.op == hxas_pkg::HXAS_SUB_ADD_EXCHANGE_OP);
				// Op picks first.hi minus second.lo or first.lo minus second.hi
				assign lanes.res_lo = hxas_wrap(sa ? lanes.a_lo : lanes.a_hi,
					sa ? lanes.b_hi : lanes.b_lo, 1'b1);
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: rtl/hxas_core.sv */
// Purpose: Execute stage for the signed halfword exchange add/sub pair
// Assumes: Decoder and register file on the same clock as this stage
// Notes:   One cycle from issue to writeback; back-to-back issue allowed
`default_nettype none
`include "hxas_params.svh"

module hxas_core
(
	input  wire logic                        SYS_CLK_IN,
	input  wire logic                        RESET_N_IN,
	input  wire logic                        CE_IN,
	input  wire logic                        ISSUE_VALID_IN,
	input  wire logic                        OP_SEL_IN,
	input  wire logic [3:0]                  COND_IN,
	input  wire logic [`HXAS_FLAG_W-1:0]     FLAGS_IN,
	input  wire logic [`HXAS_REG_IDX_W-1:0]  DEST_REG_IN,
	input  wire logic [`HXAS_REG_IDX_W-1:0]  FIRST_OPERAND_REG_IN,
	input  wire logic [`HXAS_REG_IDX_W-1:0]  SECOND_OPERAND_REG_IN,
	input  wire logic [`HXAS_WORD_W-1:0]     FIRST_OPERAND_IN,
	input  wire logic [`HXAS_WORD_W-1:0]     SECOND_OPERAND_IN,
	output logic                             WRITE_EN_OUT,
	output logic [`HXAS_REG_IDX_W-1:0]       WRITE_REG_OUT,
	output logic [`HXAS_WORD_W-1:0]          RESULT_OUT,
	output logic [`HXAS_FLAG_W-1:0]          FLAGS_OUT,
	output logic                             DONE_OUT,
	output logic                             COND_FAIL_OUT,
	output logic                             REG_FAULT_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Evaluate the condition field against the live flags
	function automatic logic hxas_cond_pass
	(
		input logic [3:0]               cond,
		input logic [`HXAS_FLAG_W-1:0]  flg
	);
		logic n;
		logic z;
		logic c;
		logic v;
		logic p;
		n = flg[`HXAS_FLAG_N_POS];
		z = flg[`HXAS_FLAG_Z_POS];
		c = flg[`HXAS_FLAG_C_POS];
		v = flg[`HXAS_FLAG_V_POS];
		case (hxas_pkg::hxas_cond_t'(cond))
			hxas_pkg::HXAS_CC_EQ: p = z;
			hxas_pkg::HXAS_CC_NE: p = ~z;
			hxas_pkg::HXAS_CC_CS: p = c;
			hxas_pkg::HXAS_CC_CC: p = ~c;
			hxas_pkg::HXAS_CC_MI: p = n;
			hxas_pkg::HXAS_CC_PL: p = ~n;
			hxas_pkg::HXAS_CC_VS: p = v;
			hxas_pkg::HXAS_CC_VC: p = ~v;
			hxas_pkg::HXAS_CC_HI: p = c & ~z;
			hxas_pkg::HXAS_CC_LS: p = ~c | z;
			hxas_pkg::HXAS_CC_GE: p = (n == v);
			hxas_pkg::HXAS_CC_LT: p = (n != v);
			hxas_pkg::HXAS_CC_GT: p = ~z & (n == v);
			hxas_pkg::HXAS_CC_LE: p = z | (n != v);
			default:              p = 1'b1; // Always, and the unused code
		endcase
		return p;
	endfunction

	// Stack pointer or program counter index, used for all three fields
	function automatic logic hxas_is_special
	(
		input logic [`HXAS_REG_IDX_W-1:0] idx
	);
		return (idx == `HXAS_SP_IDX) || (idx == `HXAS_PC_IDX);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	hxas_lane_if           lane_bus ();
	hxas_pkg::hxas_state_t state_q;
	hxas_pkg::hxas_state_t state_d;
	logic                  cond_ok;
	logic                  reg_bad;
	logic                  do_write;

	////////////////////////////////////////////////////////////////////////
	// Operand split and lane unit

	// Halves go to the lanes as raw bit patterns; sign lives in wrap-around
	assign lane_bus.a_hi = FIRST_OPERAND_IN[`HXAS_HI_MSB:`HXAS_HI_LSB];
	assign lane_bus.a_lo = FIRST_OPERAND_IN[`HXAS_LO_MSB:`HXAS_LO_LSB];
	assign lane_bus.b_hi = SECOND_OPERAND_IN[`HXAS_HI_MSB:`HXAS_HI_LSB];
	assign lane_bus.b_lo = SECOND_OPERAND_IN[`HXAS_LO_MSB:`HXAS_LO_LSB];
	assign lane_bus.op   = hxas_pkg::hxas_op_t'(OP_SEL_IN);

	hxas_lanes u_lanes
	(
		.lanes (lane_bus.lane)
	);

	////////////////////////////////////////////////////////////////////////
	// Issue qualification

	// Condition is judged on the flags as they stand at issue
	assign cond_ok = hxas_cond_pass(COND_IN, FLAGS_IN);

	// Misuse of special registers is the issuer's fault; we refuse the write
	assign reg_bad = hxas_is_special(DEST_REG_IN)
		|| hxas_is_special(FIRST_OPERAND_REG_IN)
		|| hxas_is_special(SECOND_OPERAND_REG_IN);

	assign do_write = ISSUE_VALID_IN && cond_ok && !reg_bad;

	////////////////////////////////////////////////////////////////////////
	// Writeback state machine

	// Next state follows each issue; idle when nothing comes
	always_comb
	begin
		state_d = hxas_pkg::HXAS_ST_IDLE;
		case (state_q)
			hxas_pkg::HXAS_ST_IDLE,
			hxas_pkg::HXAS_ST_WRITE,
			hxas_pkg::HXAS_ST_SKIP:
			begin
				if (do_write)
				begin
					state_d = hxas_pkg::HXAS_ST_WRITE;
				end
				else if (ISSUE_VALID_IN)
				begin
					state_d = hxas_pkg::HXAS_ST_SKIP;
				end
				else
				begin
					state_d = hxas_pkg::HXAS_ST_IDLE;
				end
			end
			default: state_d = hxas_pkg::HXAS_ST_IDLE; // Recover from bad code
		endcase
	end

	// State register, frozen while the enable is low
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			state_q <= hxas_pkg::HXAS_ST_IDLE;
		end
		else if (CE_IN)
		begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write port

	// Strobe and index update on every issue so a skip clears the strobe
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			WRITE_EN_OUT  <= 1'b0;
			WRITE_REG_OUT <= `HXAS_REG_RST;
		end
		else if (CE_IN)
		begin
			WRITE_EN_OUT <= do_write;
			if (ISSUE_VALID_IN)
			begin
				WRITE_REG_OUT <= DEST_REG_IN;
			end
		end
	end

	// Result only loads on a real write; a false condition leaves it alone
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			RESULT_OUT <= `HXAS_RESULT_RST;
		end
		else if (CE_IN && do_write)
		begin
			RESULT_OUT <= {lane_bus.res_hi, lane_bus.res_lo};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags pass through untouched

	// No arithmetic result ever reaches the flags
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			FLAGS_OUT <= `HXAS_FLAG_RST;
		end
		else if (CE_IN && ISSUE_VALID_IN)
		begin
			FLAGS_OUT <= FLAGS_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Completion reporting

	// One pulse per issue, with the reason a write was withheld
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			DONE_OUT      <= 1'b0;
			COND_FAIL_OUT <= 1'b0;
			REG_FAULT_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			DONE_OUT      <= ISSUE_VALID_IN;
			COND_FAIL_OUT <= ISSUE_VALID_IN && !cond_ok;
			REG_FAULT_OUT <= ISSUE_VALID_IN && reg_bad;
		end
	end

endmodule

`default_nettype wire

/* File: sim/hxas_chk_assertions.sv */
// Purpose: Port checks of the exchange slice
// Assumes: One clock, async active-low reset
// Notes:   Bound onto every hxas_core
`default_nettype none
module hxas_chk
(
	input wire logic        SYS_CLK_IN,
	input wire logic        RESET_N_IN,
	input wire logic        CE_IN,
	input wire logic        ISSUE_VALID_IN,
	input wire logic        OP_SEL_IN,
	input wire logic [3:0]  COND_IN,
	input wire logic [3:0]  FLAGS_IN,
	input wire logic [3:0]  DEST_REG_IN,
	input wire logic [3:0]  FIRST_OPERAND_REG_IN,
	input wire logic [3:0]  SECOND_OPERAND_REG_IN,
	input wire logic [31:0] FIRST_OPERAND_IN,
	input wire logic [31:0] SECOND_OPERAND_IN,
	input wire logic        WRITE_EN_OUT,
	input wire logic [3:0]  WRITE_REG_OUT,
	input wire logic [31:0] RESULT_OUT,
	input wire logic [3:0]  FLAGS_OUT,
	input wire logic        DONE_OUT,
	input wire logic        COND_FAIL_OUT,
	input wire logic        REG_FAULT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sixteen-bit nets so the wrap is part of the reference
	wire logic [15:0] sum_top = FIRST_OPERAND_IN[31:16] + SECOND_OPERAND_IN[15:0];
	wire logic [15:0] dif_asx = FIRST_OPERAND_IN[31:16] - SECOND_OPERAND_IN[15:0];
	wire logic [15:0] dif_sax = FIRST_OPERAND_IN[15:0] - SECOND_OPERAND_IN[31:16];
	wire logic        issue   = CE_IN && ISSUE_VALID_IN;
	// Index 13 or 15 is the only pair that reads 15 with bit 1 forced
	wire logic        bad     = (DEST_REG_IN | 4'h2) == 4'hF
		|| (FIRST_OPERAND_REG_IN | 4'h2) == 4'hF || (SECOND_OPERAND_REG_IN | 4'h2) == 4'hF;
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	a_done_after_issue: assert property (issue |=> DONE_OUT)
		else $error("done missing after issue");
	a_idle_stays_quiet: assert property (CE_IN && !ISSUE_VALID_IN |=>
		!WRITE_EN_OUT && !DONE_OUT)
		else $error("strobe without issue");
	a_flags_pass_through: assert property (issue |=> FLAGS_OUT == $past(FLAGS_IN))
		else $error("flags altered");
	a_top_half_sum: assert property (issue |=>
		WRITE_EN_OUT |-> RESULT_OUT[31:16] == $past(sum_top))
		else $error("top half wrong");
	a_asx_bottom_diff: assert property (issue && !OP_SEL_IN |=>
		WRITE_EN_OUT |-> RESULT_OUT[15:0] == $past(dif_asx))
		else $error("add-sub bottom wrong");
	a_sax_bottom_diff: assert property (issue && OP_SEL_IN |=>
		WRITE_EN_OUT |-> RESULT_OUT[15:0] == $past(dif_sax))
		else $error("sub-add bottom wrong");
	a_fail_no_write: assert property (COND_FAIL_OUT |-> !WRITE_EN_OUT && $stable(RESULT_OUT))
		else $error("write on false condition");
	a_result_needs_write: assert property ($changed(RESULT_OUT) |-> WRITE_EN_OUT && $past(issue))
		else $error("result moved without write");
	a_fault_refused: assert property (issue && bad |=> REG_FAULT_OUT && !WRITE_EN_OUT)
		else $error("special register not refused");
	a_freeze_holds: assert property (!CE_IN |=> $stable({WRITE_EN_OUT, DONE_OUT, RESULT_OUT, FLAGS_OUT}))
		else $error("outputs moved while frozen");
endmodule
bind hxas_core hxas_chk hxas_chk_i
(
	.SYS_CLK_IN            (SYS_CLK_IN),
	.RESET_N_IN            (RESET_N_IN),
	.CE_IN                 (CE_IN),
	.ISSUE_VALID_IN        (ISSUE_VALID_IN),
	.OP_SEL_IN             (OP_SEL_IN),
	.COND_IN               (COND_IN),
	.FLAGS_IN              (FLAGS_IN),
	.DEST_REG_IN           (DEST_REG_IN),
	.FIRST_OPERAND_REG_IN  (FIRST_OPERAND_REG_IN),
	.SECOND_OPERAND_REG_IN (SECOND_OPERAND_REG_IN),
	.FIRST_OPERAND_IN      (FIRST_OPERAND_IN),
	.SECOND_OPERAND_IN     (SECOND_OPERAND_IN),
	.WRITE_EN_OUT          (WRITE_EN_OUT),
	.WRITE_REG_OUT         (WRITE_REG_OUT),
	.RESULT_OUT            (RESULT_OUT),
	.FLAGS_OUT             (FLAGS_OUT),
	.DONE_OUT              (DONE_OUT),
	.COND_FAIL_OUT         (COND_FAIL_OUT),
	.REG_FAULT_OUT         (REG_FAULT_OUT)
);
`default_nettype wire

/* File: sim/hxas_regfile_model.sv */
// Purpose: Register file behind the write port
// Assumes: Write lands on the edge after the strobe
// Notes:   Combinational read port
`default_nettype none
module hxas_regfile_model
(
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [3:0]  idx_in,
	input  wire logic [31:0] data_in,
	input  wire logic [3:0]  rd_idx_in,
	output logic      [31:0] rd_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] regs_q [16] = '{default: 32'h0};
	// Only the write strobe may touch the file
	always @(posedge clk_in)
		if (we_in)
			regs_q[idx_in] <= data_in;
	assign rd_data_out = regs_q[rd_idx_in];
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench of the exchange slice
// Assumes: Inputs move 2 ns after the rising edge
// Notes:   Ends in close_out
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, vld = 1'b0, op = 1'b0;
	// Sources and destination clear of stack pointer and counter
	logic [3:0]  cond = 4'hE, flg = 4'h0, dst = 4'h3, ra = 4'h1, rb = 4'h2, ri = 4'h3;
	logic [31:0] fa = 32'h0, sb = 32'h0, ex = 32'h0, res, rd;
	logic        we, dn, cf, rf;
	logic [3:0]  wr, fo;
	logic [31:0] fv [4] = '{32'h7FFF0001, 32'h80008000, 32'h12345678, 32'hFFFF0000};
	logic [31:0] sv [4] = '{32'h00017FFF, 32'h0001FFFF, 32'h9ABCDEF0, 32'h0000FFFF};
	int          err_total = 0, samples_checked = 0, cyc = 0;
	always #12.5 clk = ~clk;
	hxas_core hxas_core_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
		.ISSUE_VALID_IN(vld), .OP_SEL_IN(op), .COND_IN(cond), .FLAGS_IN(flg),
		.DEST_REG_IN(dst), .FIRST_OPERAND_REG_IN(ra), .SECOND_OPERAND_REG_IN(rb),
		.FIRST_OPERAND_IN(fa), .SECOND_OPERAND_IN(sb), .WRITE_EN_OUT(we),
		.WRITE_REG_OUT(wr), .RESULT_OUT(res), .FLAGS_OUT(fo), .DONE_OUT(dn),
		.COND_FAIL_OUT(cf), .REG_FAULT_OUT(rf));
	hxas_regfile_model hxas_regfile_model_i (.clk_in(clk), .we_in(we), .idx_in(wr),
		.data_in(res), .rd_idx_in(ri), .rd_data_out(rd));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Wrap to sixteen bits comes from the declared widths
	function automatic logic [31:0] calc(input logic o, input logic [31:0] f,
		input logic [31:0] s);
		logic [15:0] t;
		logic [15:0] b;
		t = f[31:16] + s[15:0];
		b = o ? f[15:0] - s[31:16] : f[31:16] - s[15:0];
		return {t, b};
	endfunction
	// Odd codes up to 13 are the inverse of the even code below them; 14 and 15 both pass
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] & ~f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = ~f[2] & (f[3] == f[0]);
			default: r = ~c[0];
		endcase
		return r ^ c[0];
	endfunction
	task automatic iss(input logic o, input logic [3:0] c, input logic [3:0] fl,
		input logic [31:0] f);
		vld = 1'b1;
		op = o;
		cond = c;
		flg = fl;
		fa = f;
		@(posedge clk);
		#2;
	endtask
	task automatic idle();
		vld = 1'b0;
		@(posedge clk);
		#2;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Boundary operands, both ops, issued back to back
	task automatic t_arith();
		for (int i = 0; i < 8; i++)
		begin
			sb = sv[i / 2];
			iss(i[0], 4'hE, 4'h0, fv[i / 2]);
			ex = calc(i[0], fv[i / 2], sv[i / 2]);
			check("result", res, ex);
			check("write", {31'h0, we}, 32'h1);
			check("done", {31'h0, dn}, 32'h1);
			check("index", {28'h0, wr}, {28'h0, dst});
		end
		idle();
		check("regfile", rd, ex);
	endtask
	// Every code against every flag pattern, result held on a miss
	task automatic t_cond();
		dst = 4'h4;
		ri = 4'h4;
		for (int k = 255; k >= 0; k--)
		begin
			sb = 32'h0001FFFF + k;
			iss(k[0], k[7:4], k[3:0], 32'h7FFF0000 + k);
			if (cond_ok(k[7:4], k[3:0]))
				ex = calc(k[0], fa, sb);
			check("cond fail", {31'h0, cf}, {31'h0, ~cond_ok(k[7:4], k[3:0])});
			check("result", res, ex);
			check("flags", {28'h0, fo}, {28'h0, k[3:0]});
		end
		idle();
		check("regfile", rd, ex);
	endtask
	// Stack pointer or counter in each field, then a frozen issue
	task automatic t_fault();
		for (int j = 0; j < 3; j++)
		begin
			{dst, ra, rb} = {4'h5, 4'h1, 4'h2};
			{dst, ra, rb} = (j == 0) ? {4'hD, ra, rb}
				: (j == 1) ? {dst, 4'hF, rb} : {dst, ra, 4'hD};
			iss(1'b0, 4'hE, 4'h0, 32'h11112222);
			check("fault", {30'h0, rf, we}, 32'h2);
			check("result", res, ex);
		end
		idle();
		ce = 1'b0;
		// New flags on the frozen issue must not reach the flag copy
		iss(1'b0, 4'hE, 4'hF, 32'h33334444);
		check("frozen", {31'h0, dn}, 32'h0);
		check("frozen result", res, ex);
		check("frozen flags", {28'h0, fo}, 32'h0);
		ce = 1'b1;
		idle();
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			close_out();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		#2;
		rst_n = 1'b1;
		t_arith();
		t_cond();
		t_fault();
		close_out();
	end
endmodule
`default_nettype wire
